/* design/iam_entry_match.sv */
// Match logic for one access control entry against parsed IP header fields
// Function
// - Fragment No blocks fragmented IPv4 frames; Yes needs fragment; Any ignores it
// - Options No blocks IPv4 frames with options; Yes needs options; Any ignores
// - Source IPv4 filter Any ignores the frame source address
// - Source IPv4 filter Host needs an exact source address match
// - Source IPv4 filter Network compares only bits set in the mask
// - Destination IPv4 filter Any ignores the frame destination address
// - Destination IPv4 filter Host needs an exact destination address match
// - Destination IPv4 filter Network compares only bits set in the mask
// - Next header filter Any ignores the IPv6 next header
// - Next header Specific needs next header equal to the configured byte
// - Next header ICMP, UDP or TCP needs that upper-layer protocol
// - IPv6 source filter Any ignores the IPv6 source address
// - IPv6 source Specific compares only the low 32 address bits
// - Zero bits of the IPv6 source mask are left out of the compare
// - Hop limit zero blocks nonzero hop limits; non-zero needs one; Any ignores
// - IPv4 criteria apply only to entries whose frame type is IPv4
`timescale 1ns/1ns
`default_nettype none
module iam_entry_match #(
  parameter int unsigned FRAG_OFF_W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // Parsed frame header
  input wire logic hdr_valid,
  input wire logic hdr_is_ipv4,
  input wire logic hdr_is_ipv6,
  input wire logic more_fragments_flag,
  input wire logic [FRAG_OFF_W-1:0] fragment_offset_field,
  input wire logic hdr_options_flag,
  input wire logic [31:0] source_ipv4_addr,
  input wire logic [31:0] destination_ipv4_addr,
  input wire logic [7:0] hdr_next_header,
  input wire logic [31:0] source_v6_addr_low,
  input wire logic [7:0] hdr_hop_limit,
  // Match result
  output logic hit_valid_q,
  output logic hit_q
);

  generate
    if (FRAG_OFF_W < 1 || FRAG_OFF_W > 16) begin : g_bad_frag_w
      $error("iam_entry_match FRAG_OFF_W must be 1 to 16");
    end
  endgenerate

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [31:0] sip_addr_q;
  logic [31:0] sip_mask_q;
  logic [31:0] dip_addr_q;
  logic [31:0] dip_mask_q;
  logic [7:0] nh_val_q;
  logic [31:0] sip6_addr_q;
  logic [31:0] sip6_mask_q;
  logic [15:0] hit_cnt_q;
  logic last_hit_q;
  logic seen_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= iam_pkg::CTRL_RST;
      sip_addr_q <= iam_pkg::ADDR_RST;
      sip_mask_q <= iam_pkg::MASK_RST;
      dip_addr_q <= iam_pkg::ADDR_RST;
      dip_mask_q <= iam_pkg::MASK_RST;
      nh_val_q <= iam_pkg::NH_RST;
      sip6_addr_q <= iam_pkg::ADDR_RST;
      sip6_mask_q <= iam_pkg::MASK_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        iam_pkg::OFS_CTRL: ctrl_q <= reg_wdata[15:0];
        iam_pkg::OFS_SIP_ADDR: sip_addr_q <= reg_wdata;
        iam_pkg::OFS_SIP_MASK: sip_mask_q <= reg_wdata;
        iam_pkg::OFS_DIP_ADDR: dip_addr_q <= reg_wdata;
        iam_pkg::OFS_DIP_MASK: dip_mask_q <= reg_wdata;
        iam_pkg::OFS_NH_VAL: nh_val_q <= reg_wdata[7:0];
        iam_pkg::OFS_SIP6_ADDR: sip6_addr_q <= reg_wdata;
        iam_pkg::OFS_SIP6_MASK: sip6_mask_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  logic [1:0] ft_mode;
  logic [1:0] frag_mode;
  logic [1:0] opt_mode;
  logic [1:0] sip_mode;
  logic [1:0] dip_mode;
  logic [2:0] nh_mode;
  logic sip6_spec;
  logic [1:0] hop_mode;
  logic [1:0] sip6_af_mode;

  assign ft_mode = ctrl_q[iam_pkg::FT_LSB +: 2];
  assign frag_mode = ctrl_q[iam_pkg::FRAG_LSB +: 2];
  assign opt_mode = ctrl_q[iam_pkg::OPT_LSB +: 2];
  assign sip_mode = ctrl_q[iam_pkg::SIP_LSB +: 2];
  assign dip_mode = ctrl_q[iam_pkg::DIP_LSB +: 2];
  assign nh_mode = ctrl_q[iam_pkg::NH_LSB +: 3];
  assign sip6_spec = ctrl_q[iam_pkg::SIP6_LSB];
  assign hop_mode = ctrl_q[iam_pkg::HOP_LSB +: 2];
  assign sip6_af_mode = sip6_spec ? iam_pkg::AF_NET : iam_pkg::AF_ANY;

  // ----------------------------------------
  // Criteria
  // ----------------------------------------
  logic frag_seen;
  logic frag_ok;
  logic opt_ok;
  logic sip_ok;
  logic dip_ok;
  logic nh_ok;
  logic sip6_ok;
  logic hop_ok;
  logic v4_ok;
  logic v6_ok;
  logic hit_d;

  assign frag_seen = more_fragments_flag || (fragment_offset_field != '0);
  assign frag_ok = iam_pkg::tri_ok(frag_mode, frag_seen);
  assign opt_ok = iam_pkg::tri_ok(opt_mode, hdr_options_flag);
  assign hop_ok = iam_pkg::tri_ok(hop_mode, hdr_hop_limit != 8'h00);

  iam_addr_filter #(.W(32)) u_sip (
    .mode(sip_mode),
    .cfg_addr(sip_addr_q),
    .cfg_mask(sip_mask_q),
    .frame_addr(source_ipv4_addr),
    .match(sip_ok)
  );

  iam_addr_filter #(.W(32)) u_dip (
    .mode(dip_mode),
    .cfg_addr(dip_addr_q),
    .cfg_mask(dip_mask_q),
    .frame_addr(destination_ipv4_addr),
    .match(dip_ok)
  );

  // Low 32 source bits under the bitmask
  iam_addr_filter #(.W(32)) u_sip6 (
    .mode(sip6_af_mode),
    .cfg_addr(sip6_addr_q),
    .cfg_mask(sip6_mask_q),
    .frame_addr(source_v6_addr_low),
    .match(sip6_ok)
  );

  always_comb begin
    case (nh_mode)
      iam_pkg::NH_ANY: nh_ok = 1'b1;
      iam_pkg::NH_SPECIFIC: nh_ok = (hdr_next_header == nh_val_q);
      iam_pkg::NH_ICMP: nh_ok = (hdr_next_header == iam_pkg::PROTO_ICMP6);
      iam_pkg::NH_UDP: nh_ok = (hdr_next_header == iam_pkg::PROTO_UDP);
      iam_pkg::NH_TCP: nh_ok = (hdr_next_header == iam_pkg::PROTO_TCP);
      default: nh_ok = 1'b0;
    endcase
  end

  assign v4_ok = frag_ok && opt_ok && sip_ok && dip_ok;
  assign v6_ok = nh_ok && sip6_ok && hop_ok;

  // IPv4 criteria only for IPv4 entries
  always_comb begin
    case (ft_mode)
      iam_pkg::FT_ANY: hit_d = 1'b1;
      iam_pkg::FT_IPV4: hit_d = hdr_is_ipv4 && v4_ok;
      iam_pkg::FT_IPV6: hit_d = hdr_is_ipv6 && v6_ok;
      default: hit_d = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Result
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hit_valid_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      hit_valid_q <= hdr_valid;
      hit_q <= hdr_valid && hit_d;
    end
  end

  // ----------------------------------------
  // Status: last result and hit count
  // ----------------------------------------
  logic status_clr;
  assign status_clr = reg_wr && (reg_addr == iam_pkg::OFS_STATUS);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hit_cnt_q <= 16'h0000;
      last_hit_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (status_clr) begin
        hit_cnt_q <= {15'h0000, hit_valid_q && hit_q};
        seen_q <= hit_valid_q;
      end else begin
        if (hit_valid_q && hit_q) begin
          hit_cnt_q <= hit_cnt_q + 16'h0001;
        end
        if (hit_valid_q) begin
          seen_q <= 1'b1;
        end
      end
      if (hit_valid_q) begin
        last_hit_q <= hit_q;
      end else if (status_clr) begin
        last_hit_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[iam_pkg::ST_HIT_BIT] = last_hit_q;
    status_word[iam_pkg::ST_SEEN_BIT] = seen_q;
    status_word[iam_pkg::ST_CNT_LSB +: 16] = hit_cnt_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        iam_pkg::OFS_CTRL: reg_rdata_q <= {16'h0000, ctrl_q};
        iam_pkg::OFS_SIP_ADDR: reg_rdata_q <= sip_addr_q;
        iam_pkg::OFS_SIP_MASK: reg_rdata_q <= sip_mask_q;
        iam_pkg::OFS_DIP_ADDR: reg_rdata_q <= dip_addr_q;
        iam_pkg::OFS_DIP_MASK: reg_rdata_q <= dip_mask_q;
        iam_pkg::OFS_NH_VAL: reg_rdata_q <= {24'h000000, nh_val_q};
        iam_pkg::OFS_SIP6_ADDR: reg_rdata_q <= sip6_addr_q;
        iam_pkg::OFS_SIP6_MASK: reg_rdata_q <= sip6_mask_q;
        iam_pkg::OFS_STATUS: reg_rdata_q <= status_word;
        default: reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_frag_no_block: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && frag_mode == iam_pkg::TRI_NO && frag_seen) |=> !hit_q)
    else $error("fragmented frame hit with fragment criterion No");

  a_opt_yes_need: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && opt_mode == iam_pkg::TRI_YES && !hdr_options_flag)
    |=> (hit_valid_q && !hit_q))
    else $error("frame without options hit with options criterion Yes");

  a_sip_host_exact: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && sip_mode == iam_pkg::AF_HOST && source_ipv4_addr != sip_addr_q)
    |=> !hit_q)
    else $error("source host filter hit on different address");

  a_sip_net_mask: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && sip_mode == iam_pkg::AF_NET
     && ((source_ipv4_addr ^ sip_addr_q) & sip_mask_q) != 32'h0000_0000) |=> !hit_q)
    else $error("source network filter hit outside mask");

  a_dip_host_exact: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && dip_mode == iam_pkg::AF_HOST
     && destination_ipv4_addr != dip_addr_q) |=> !hit_q)
    else $error("destination host filter hit on different address");

  a_dip_net_mask: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && dip_mode == iam_pkg::AF_NET
     && ((destination_ipv4_addr ^ dip_addr_q) & dip_mask_q) != 32'h0000_0000) |=> !hit_q)
    else $error("destination network filter hit outside mask");

  a_nh_tcp_num: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV6 && nh_mode == iam_pkg::NH_TCP && hdr_next_header != 8'h06)
    |=> !hit_q)
    else $error("TCP next header filter hit on other protocol");

  a_sip6_mask_low: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV6 && sip6_spec
     && ((source_v6_addr_low ^ sip6_addr_q) & sip6_mask_q) != 32'h0000_0000) |=> !hit_q)
    else $error("IPv6 source filter hit outside bitmask");

  a_hop_zero_block: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV6 && hop_mode == iam_pkg::TRI_NO && hdr_hop_limit != 8'h00)
    |=> !hit_q)
    else $error("nonzero hop limit hit with hop criterion zero");

  a_any_entry_hit: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ctrl_q == 16'h0000) |=> (hit_valid_q && hit_q))
    else $error("entry with all criteria any failed to hit");

  a_v4_on_v6_frame: assert property (
    @(posedge clk) disable iff (!resetn)
    (hdr_valid && ft_mode == iam_pkg::FT_IPV4 && !hdr_is_ipv4) |=> !hit_q)
    else $error("IPv4 entry hit on a non IPv4 frame");

endmodule : iam_entry_match
`default_nettype wire

/* design/iam_pkg.sv */
// Constants shared by the access control entry match logic
package iam_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SIP_ADDR = 8'h04;
  localparam logic [7:0] OFS_SIP_MASK = 8'h08;
  localparam logic [7:0] OFS_DIP_ADDR = 8'h0C;
  localparam logic [7:0] OFS_DIP_MASK = 8'h10;
  localparam logic [7:0] OFS_NH_VAL = 8'h14;
  localparam logic [7:0] OFS_SIP6_ADDR = 8'h18;
  localparam logic [7:0] OFS_SIP6_MASK = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int unsigned FT_LSB = 0;
  localparam int unsigned FRAG_LSB = 2;
  localparam int unsigned OPT_LSB = 4;
  localparam int unsigned SIP_LSB = 6;
  localparam int unsigned DIP_LSB = 8;
  localparam int unsigned NH_LSB = 10;
  localparam int unsigned SIP6_LSB = 13;
  localparam int unsigned HOP_LSB = 14;
  localparam int unsigned CTRL_W = 16;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int unsigned ST_HIT_BIT = 0;
  localparam int unsigned ST_SEEN_BIT = 1;
  localparam int unsigned ST_CNT_LSB = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  localparam logic [7:0] NH_RST = 8'h00;

  // ----------------------------------------
  // Mode encodings
  // ----------------------------------------
  localparam logic [1:0] FT_ANY = 2'h0;
  localparam logic [1:0] FT_IPV4 = 2'h1;
  localparam logic [1:0] FT_IPV6 = 2'h2;

  localparam logic [1:0] TRI_ANY = 2'h0;
  localparam logic [1:0] TRI_NO = 2'h1;
  localparam logic [1:0] TRI_YES = 2'h2;

  localparam logic [1:0] AF_ANY = 2'h0;
  localparam logic [1:0] AF_HOST = 2'h1;
  localparam logic [1:0] AF_NET = 2'h2;

  localparam logic [2:0] NH_ANY = 3'h0;
  localparam logic [2:0] NH_SPECIFIC = 3'h1;
  localparam logic [2:0] NH_ICMP = 3'h2;
  localparam logic [2:0] NH_UDP = 3'h3;
  localparam logic [2:0] NH_TCP = 3'h4;

  // ----------------------------------------
  // Upper-layer protocol numbers
  // ----------------------------------------
  localparam logic [7:0] PROTO_ICMP6 = 8'h3A;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [7:0] PROTO_TCP = 8'h06;

  // Three-way criterion: any, flag must be clear, flag must be set
  function automatic logic tri_ok(input logic [1:0] mode, input logic flag);
    case (mode)
      TRI_ANY: tri_ok = 1'b1;
      TRI_NO: tri_ok = !flag;
      TRI_YES: tri_ok = flag;
      default: tri_ok = 1'b0;
    endcase
  endfunction : tri_ok

endpackage : iam_pkg

/* design/iam_addr_filter.sv */
// Address filter: any, exact host, or masked network compare
`timescale 1ns/1ns
`default_nettype none
module iam_addr_filter #(
  parameter int unsigned W = 32
) (
  // Configuration
  input wire logic [1:0] mode,
  input wire logic [W-1:0] cfg_addr,
  input wire logic [W-1:0] cfg_mask,
  // Frame field
  input wire logic [W-1:0] frame_addr,
  // Result
  output logic match
);

  generate
    if (W < 1) begin : g_bad_width
      $error("iam_addr_filter width must be at least one");
    end
  endgenerate

  always_comb begin
    case (mode)
      iam_pkg::AF_ANY: match = 1'b1;
      iam_pkg::AF_HOST: match = (frame_addr == cfg_addr);
      iam_pkg::AF_NET: match = (((frame_addr ^ cfg_addr) & cfg_mask) == '0);
      default: match = 1'b0;
    endcase
  end

endmodule : iam_addr_filter
`default_nettype wire

/* sim/iam_parser_model.sv */
// Frame header parser model feeding decoded fields to the match logic
`timescale 1ns/1ns
`default_nettype none
module iam_parser_model #(
  parameter int unsigned OW = 16
) (
  // Clock
  input wire logic clk,
  // Request from bench
  input wire logic send,
  input wire logic [131:0] fields,
  // Parsed header
  output logic hdr_valid,
  output logic hdr_is_ipv4,
  output logic hdr_is_ipv6,
  output logic more_fragments_flag,
  output logic hdr_options_flag,
  output logic [OW-1:0] fragment_offset_field,
  output logic [31:0] source_ipv4_addr,
  output logic [31:0] destination_ipv4_addr,
  output logic [7:0] hdr_next_header,
  output logic [31:0] source_v6_addr_low,
  output logic [7:0] hdr_hop_limit
);
  logic [131:0] hdr_q = 132'h0;

  // Fields outside a header strobe toggle every cycle
  always_ff @(posedge clk) begin
    hdr_valid <= send;
    hdr_q <= send ? fields : ~hdr_q;
  end

  assign {hdr_is_ipv4, hdr_is_ipv6, more_fragments_flag, hdr_options_flag} = hdr_q[131:128];
  assign fragment_offset_field = hdr_q[112+:OW];
  assign {source_ipv4_addr, destination_ipv4_addr, hdr_next_header} = hdr_q[111:40];
  assign {source_v6_addr_low, hdr_hop_limit} = hdr_q[39:0];
endmodule : iam_parser_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the access control entry match logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata_q;
  logic hit_valid_q, hit_q, send = 1'h0;
  logic [131:0] fields = 132'h0;
  logic hv, h4, h6, hmf, hopt;
  logic [15:0] hoff;
  logic [31:0] hsip, hdip, hs6;
  logic [7:0] hnh, hhop;
  logic [31:0] cfg [0:7] = '{32'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFFFF};
  logic f4 = 1'h0, f6 = 1'h0, fmf = 1'h0, fopt = 1'h0;
  logic [15:0] foff = 16'h0;
  logic [31:0] fsip = 32'h0, fdip = 32'h0, fs6 = 32'h0;
  logic [7:0] fnh = 8'h00, fhop = 8'h00;
  logic [1:0] p_v = 2'h0, p_h = 2'h0;
  logic [15:0] hits = 16'h0;
  logic seen = 1'h0, last = 1'h0;
  int error_cnt = 0;
  int total_checks = 0;

  always #10 clk = ~clk;

  iam_parser_model #(.OW(16)) partner (.clk(clk), .send(send), .fields(fields), .hdr_valid(hv),
    .hdr_is_ipv4(h4), .hdr_is_ipv6(h6), .more_fragments_flag(hmf), .hdr_options_flag(hopt),
    .fragment_offset_field(hoff), .source_ipv4_addr(hsip), .destination_ipv4_addr(hdip),
    .hdr_next_header(hnh), .source_v6_addr_low(hs6), .hdr_hop_limit(hhop));

  iam_entry_match #(.FRAG_OFF_W(16)) dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .hdr_valid(hv), .hdr_is_ipv4(h4), .hdr_is_ipv6(h6), .more_fragments_flag(hmf),
    .fragment_offset_field(hoff), .hdr_options_flag(hopt), .source_ipv4_addr(hsip),
    .destination_ipv4_addr(hdip), .hdr_next_header(hnh), .source_v6_addr_low(hs6),
    .hdr_hop_limit(hhop), .hit_valid_q(hit_valid_q), .hit_q(hit_q));

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic tri3(input logic [1:0] m, input logic f);
    return (m == 2'h0) ? 1'h1 : (m == 2'h1) ? !f : (m == 2'h2) ? f : 1'h0;
  endfunction : tri3

  function automatic logic af(input logic [1:0] m, input logic [31:0] a, input logic [31:0] c, input logic [31:0] k);
    return (m == 2'h0) ? 1'h1 : (m == 2'h1) ? (a == c) : (m == 2'h2) ? (((a ^ c) & k) == 32'h0) : 1'h0;
  endfunction : af

  function automatic logic exp_hit();
    logic [15:0] c;
    logic [7:0] want;
    c = cfg[0][15:0];
    case (c[12:10])
      3'h1: want = cfg[5][7:0];
      3'h2: want = 8'h3A;
      3'h3: want = 8'h11;
      default: want = 8'h06;
    endcase
    if (c[1:0] == 2'h0) return 1'h1;
    if (c[1:0] == 2'h1) return f4 && tri3(c[3:2], fmf || foff != 16'h0) && tri3(c[5:4], fopt)
      && af(c[7:6], fsip, cfg[1], cfg[2]) && af(c[9:8], fdip, cfg[3], cfg[4]);
    if (c[1:0] == 2'h2) return f6 && (c[12:10] == 3'h0 || (c[12:10] < 3'h5 && fnh == want))
      && (!c[13] || ((fs6 ^ cfg[6]) & cfg[7]) == 32'h0) && tri3(c[15:14], fhop != 8'h00);
    return 1'h0;
  endfunction : exp_hit

  function automatic logic [31:0] near(input logic [31:0] c);
    logic [31:0] r;
    r = $urandom;
    return (r[1:0] == 2'h0) ? r : (r[1:0] == 2'h1) ? c ^ (32'h1 << r[6:2]) : c;
  endfunction : near

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    if (a < 8'h20) cfg[a[4:2]] = d & ((a == 8'h00) ? 32'hFFFF : (a == 8'h14) ? 32'hFF : 32'hFFFFFFFF);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    check("reg_rdata_q", exp, reg_rdata_q);
    @(negedge clk);
    check("reg_rdata_q idle", 32'h0, reg_rdata_q);
  endtask : reg_read

  task automatic cycle(input logic v);
    logic e;
    e = v & exp_hit();
    @(posedge clk);
    send <= v;
    fields <= {f4, f6, fmf, fopt, foff, fsip, fdip, fnh, fs6, fhop};
    @(negedge clk);
    check("hit_valid_q", {31'h0, p_v[1]}, {31'h0, hit_valid_q});
    check("hit_q", {31'h0, p_h[1]}, {31'h0, hit_q});
    p_v = {p_v[0], v};
    p_h = {p_h[0], e};
    hits = hits + {15'h0, e};
    seen = seen | v;
    last = v ? e : last;
  endtask : cycle

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    void'($urandom(93));
    repeat (16) @(posedge clk);
    check("reset outputs", 32'h0, {30'h0, hit_valid_q, hit_q} | reg_rdata_q);
    resetn <= 1'h1;
    for (int i = 0; i < 8; i++) reg_read({i[5:0], 2'h0}, cfg[i]);
    reg_write(8'h24, 32'hFFFFFFFF);
    reg_read(8'h24, 32'h0);
    reg_read(8'h02, 32'h0);
    $display("test registers done");
    reg_write(8'h00, 32'h0);
    cycle(1'h1);
    cycle(1'h0);
    cycle(1'h0);
    reg_write(8'h00, 32'h2002);
    reg_write(8'h18, 32'h3);
    reg_write(8'h1C, 32'hFFFFFFFE);
    f6 = 1'h1;
    for (int k = 0; k < 4; k++) begin
      fs6 = 32'h2 + k;
      cycle(1'h1);
    end
    cycle(1'h0);
    cycle(1'h0);
    for (int k = 2; k < 5; k++) begin
      reg_write(8'h00, 32'h0002 | (k << 10));
      for (int n = 0; n < 4; n++) begin
        fnh = (n == 0) ? 8'h3A : (n == 1) ? 8'h11 : (n == 2) ? 8'h06 : 8'h07;
        cycle(1'h1);
      end
      cycle(1'h0);
      cycle(1'h0);
    end
    reg_write(8'h00, 32'h0005);
    {f4, f6, fmf, foff} = {3'h4, 16'h0001};
    cycle(1'h1);
    cycle(1'h0);
    cycle(1'h0);
    $display("test corners done");
    reg_write(8'h20, 32'h0);
    {hits, seen, last} = 18'h0;
    for (int c = 0; c < 40; c++) begin
      reg_write(8'h00, $urandom);
      for (int i = 1; i < 8; i++) reg_write({i[5:0], 2'h0}, $urandom);
      reg_read(8'h00, cfg[0]);
      reg_read(8'h14, cfg[5]);
      for (int n = 0; n < 24; n++) begin
        r = $urandom;
        {f4, f6, fmf, fopt} = {r[0], r[1], r[2] & r[3], r[4]};
        foff = r[5] ? 16'h0 : r[31:16];
        fhop = r[6] ? 8'h00 : r[15:8];
        fsip = near(cfg[1]);
        fdip = near(cfg[3]);
        fs6 = near(cfg[6]);
        fnh = r[8] ? cfg[5][7:0] : r[9] ? 8'h3A : r[10] ? 8'h11 : r[11] ? 8'h06 : r[23:16];
        cycle(r[13:12] != 2'h0);
      end
      cycle(1'h0);
      cycle(1'h0);
    end
    reg_read(8'h20, {hits, 14'h0, seen, last});
    $display("test random done");
    print_verdict();
  end

  initial begin
    #2000000;
    error_cnt++;
    $display("watchdog limit reached");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
